// [core/ddh_host_if.v]
// drive-side logic of the cabled controller interface (select, tags, status)
// assumes the cable inputs are asynchronous; link clock sampled as a plain input
// What this block does
// - select by address match, within 600 ns
// - bus bit 9 priority select reserves
// - accept only own plug address
// - unit selected output after acceptance
// - cable sense inactive inhibits select, tags and status except address mark found
// - ready: speed, on cylinder, no fault
// - one index pulse per revolution
// - busy when other channel holds drive
// - write protect; write attempt faults
// - on cylinder while positioned on track
// - seek error: timeout, outside, over 822
// - fault from five listed causes
// - tag 1 loads cylinder address
// - tag 2 loads head address
// - gates refused under seek error/fault
// - read gate edge starts zero sync
// - offsets suppress on cylinder 2.75 ms
// - fault clear only if cause gone
// - address mark write and search
// - return to zero resets registers
// - release clears reserve, priority reserve
// - servo clock out, write clock back
// - tag 1-3 receivers and status off when unselected; busy, address mark found, write data not gated
// - no plug single channel uses 7
`timescale 1ns/10ps
`default_nettype none
`include "ddh_defines.vh"
module ddh_host_if #(
   parameter SEEK_CYC = `DDH_SEEK_CYC,
   parameter OFS_CYC = `DDH_OFS_CYC
) (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg wb_ack_o,
   input wire unit_sel_tag_i,
   input wire [3:0] unit_sel_i,
   input wire cable_sense_i,
   input wire tag1_i,
   input wire tag2_i,
   input wire tag3_i,
   input wire [9:0] bus_i,
   input wire servo_clk_i,
   input wire write_clk_i,
   input wire write_data_i,
   output reg unit_selected_o,
   output reg busy_o,
   output reg ready_o,
   output reg index_o,
   output reg on_cyl_o,
   output reg seek_err_o,
   output reg fault_o,
   output reg wprot_o,
   output reg am_found_o,
   output reg servo_clk_o,
   output reg write_en_o,
   output reg read_en_o,
   output reg am_write_o,
   output reg read_sync_o,
   output reg rtz_o,
   output reg [1:0] offset_o,
   output reg wr_data_o
);
   localparam CYL_W = 10;
   localparam HEAD_W = 4;
   localparam SEL_IDLE = 2'd0;
   localparam SEL_CMP = 2'd1;
   localparam SEL_DONE = 2'd2;
   localparam [31:0] OFS_LD = OFS_CYC;

   function edge_rise;
      input cur;
      input prev;
      begin
         edge_rise = cur & ~prev;
      end
   endfunction

   // two-stage synchronisers for all cable inputs
   reg [21:0] s1_r;
   reg [21:0] s2_r;
   reg [21:0] s3_r;
   wire [21:0] raw = {write_data_i, write_clk_i, servo_clk_i, bus_i, tag3_i, tag2_i,
      tag1_i, cable_sense_i, unit_sel_i, unit_sel_tag_i};
   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= 22'h000000;
         s2_r <= 22'h000000;
         s3_r <= 22'h000000;
      end else begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   wire ust = s2_r[0];
   wire [3:0] usel = s2_r[4:1];
   wire sense = s2_r[5];
   wire t1 = s2_r[6];
   wire t2 = s2_r[7];
   wire t3 = s2_r[8];
   wire [9:0] bus = s2_r[18:9];
   wire sclk = s2_r[19];
   wire wclk = s2_r[20];
   wire wdat = s2_r[21];
   wire t1_p = edge_rise(t1, s3_r[6]);
   wire t2_p = edge_rise(t2, s3_r[7]);
   wire t3_p = edge_rise(t3, s3_r[8]);
   wire ust_p = edge_rise(ust, s3_r[0]);

   // software registers
   reg [15:0] ctrl_r;
   reg [4:0] plug_r;
   wire dual = ctrl_r[`DDH_CTRL_DUAL];
   wire plug_fit = plug_r[4];
   wire [3:0] my_addr = plug_fit ? plug_r[3:0] : (dual ? 4'hF : `DDH_ADDR_NOPLUG);

   // selection
   reg [1:0] sel_st_r;
   reg selected_r;
   reg reserved_r;
   reg pri_res_r;
   reg [9:0] cyl_r;
   reg [3:0] head_r;
   reg seek_err_r;
   reg fault_r;
   reg wg_r;
   reg rg_r;
   wire oth_pri = ctrl_r[`DDH_CTRL_OTHPRI];
   wire oth_hold = ctrl_r[`DDH_CTRL_OTHHOLD];
   wire ch_en = ctrl_r[`DDH_CTRL_CHEN];
   wire code_ok = dual | ~usel[3];
   wire match = code_ok & (usel == my_addr);
   wire pri_sel = dual & bus[`DDH_PRI_BIT] & ch_en & ~oth_pri;
   wire blocked = dual & oth_hold & ~pri_sel;
   wire cmd_ok = selected_r & sense;
   always @(posedge clk_i) begin
      if (rst_i) begin
         sel_st_r <= SEL_IDLE;
         selected_r <= 1'b0;
         reserved_r <= 1'b0;
         pri_res_r <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         if (!sense) begin
            sel_st_r <= SEL_IDLE;
            selected_r <= 1'b0;
            busy_o <= 1'b0;
         end else begin
            case (sel_st_r)
               SEL_IDLE: begin
                  if (ust_p) begin
                     sel_st_r <= SEL_CMP;
                  end
               end
               SEL_CMP: begin
                  if (match && !blocked) begin
                     selected_r <= 1'b1;
                     busy_o <= 1'b0;
                     if (dual) begin
                        reserved_r <= 1'b1;
                        pri_res_r <= pri_sel;
                     end
                     sel_st_r <= SEL_DONE;
                  end else begin
                     busy_o <= match & blocked;
                     selected_r <= 1'b0;
                     sel_st_r <= SEL_DONE;
                  end
               end
               default: begin
                  if (!ust) begin
                     sel_st_r <= SEL_IDLE;
                  end
                  if (ust && !match) begin
                     selected_r <= 1'b0;
                  end
               end
            endcase
            if (cmd_ok && t3_p && dual && bus[`DDH_T3_REL]) begin
               reserved_r <= 1'b0;
               pri_res_r <= 1'b0;
            end
         end
      end
   end

   // drive condition inputs from software
   wire at_speed = ctrl_r[`DDH_CTRL_SPEED];
   wire pos_on = ctrl_r[`DDH_CTRL_ONCYL];
   reg [23:0] ofs_cnt_r;
   reg [31:0] seek_cnt_r;
   wire offsetting = |ofs_cnt_r;
   wire on_cyl = pos_on & ~offsetting;
   wire wprot = ctrl_r[`DDH_CTRL_SWPROT] | fault_r;
   wire wg_req = t3_p & bus[`DDH_T3_WGATE];
   wire rg_req = t3_p & bus[`DDH_T3_RGATE];
   wire flt_cause = ctrl_r[`DDH_CTRL_FSKFLT] | ctrl_r[`DDH_CTRL_DCFLT] | ctrl_r[`DDH_CTRL_WRFLT]
      | ((wg_r | rg_r) & ~on_cyl) | (wg_r & rg_r);
   wire flt_evt = cmd_ok & ((wg_req & wprot) | ((wg_req | rg_req) & ~on_cyl)
      | (wg_req & rg_req));
   wire t3_go = cmd_ok & t3_p;
   always @(posedge clk_i) begin
      if (rst_i) begin
         cyl_r <= 10'h000;
         head_r <= 4'h0;
         seek_err_r <= 1'b0;
         fault_r <= 1'b0;
         wg_r <= 1'b0;
         rg_r <= 1'b0;
         ofs_cnt_r <= 24'h000000;
         seek_cnt_r <= 32'h00000000;
         offset_o <= 2'b00;
         am_write_o <= 1'b0;
         am_found_o <= 1'b0;
         read_sync_o <= 1'b0;
         rtz_o <= 1'b0;
      end else begin
         read_sync_o <= 1'b0;
         rtz_o <= 1'b0;
         if (cmd_ok && t1_p) begin
            cyl_r <= bus[CYL_W-1:0];
            seek_cnt_r <= SEEK_CYC;
            if (bus[CYL_W-1:0] > `DDH_CYL_MAX) begin
               seek_err_r <= 1'b1;
            end
         end else if (seek_cnt_r != 32'h00000000) begin
            if (pos_on) begin
               seek_cnt_r <= 32'h00000000;
            end else if (seek_cnt_r == 32'h00000001) begin
               seek_err_r <= 1'b1;
               seek_cnt_r <= 32'h00000000;
            end else begin
               seek_cnt_r <= seek_cnt_r - 32'h00000001;
            end
         end
         if (ctrl_r[`DDH_CTRL_OUTFLD]) begin
            seek_err_r <= 1'b1;
         end
         if (cmd_ok && t2_p) begin
            head_r <= bus[HEAD_W-1:0];
         end
         if (t3_go) begin
            wg_r <= bus[`DDH_T3_WGATE] & ~seek_err_r & ~fault_r & ~wprot;
            rg_r <= bus[`DDH_T3_RGATE] & ~seek_err_r & ~fault_r;
            read_sync_o <= bus[`DDH_T3_RGATE] & ~rg_r & ~seek_err_r & ~fault_r;
            offset_o <= {bus[`DDH_T3_OFSM], bus[`DDH_T3_OFSP]};
            if (bus[`DDH_T3_OFSP] || bus[`DDH_T3_OFSM]) begin
               ofs_cnt_r <= OFS_LD[23:0];
            end
            am_write_o <= bus[`DDH_T3_AME] & bus[`DDH_T3_WGATE];
            if (bus[`DDH_T3_AME] && bus[`DDH_T3_RGATE]) begin
               am_found_o <= 1'b0;
            end
            if (bus[`DDH_T3_RTZ]) begin
               rtz_o <= 1'b1;
               cyl_r <= 10'h000;
               head_r <= 4'h0;
               seek_err_r <= 1'b0;
               seek_cnt_r <= 32'h00000000;
            end
         end else if (offsetting) begin
            ofs_cnt_r <= ofs_cnt_r - 24'h000001;
         end
         if (rg_r && ctrl_r[`DDH_CTRL_AMDET]) begin
            am_found_o <= 1'b1;
         end
         // fault set wins; clear if gone
         if (flt_evt || flt_cause) begin
            fault_r <= 1'b1;
         end else if (t3_go && bus[`DDH_T3_FCLR]) begin
            fault_r <= 1'b0;
         end
      end
   end

   // status drivers gated when unselected; servo clock, gate enables and write data not gated
   reg idx_d_r;
   always @(posedge clk_i) begin
      if (rst_i) begin
         unit_selected_o <= 1'b0;
         ready_o <= 1'b0;
         index_o <= 1'b0;
         idx_d_r <= 1'b0;
         on_cyl_o <= 1'b0;
         seek_err_o <= 1'b0;
         fault_o <= 1'b0;
         wprot_o <= 1'b0;
         servo_clk_o <= 1'b0;
         write_en_o <= 1'b0;
         read_en_o <= 1'b0;
         wr_data_o <= 1'b0;
      end else begin
         unit_selected_o <= cmd_ok;
         ready_o <= cmd_ok & at_speed & on_cyl & ~fault_r;
         idx_d_r <= ctrl_r[`DDH_CTRL_INDEX];
         index_o <= cmd_ok & edge_rise(ctrl_r[`DDH_CTRL_INDEX], idx_d_r);
         on_cyl_o <= cmd_ok & on_cyl;
         seek_err_o <= cmd_ok & seek_err_r;
         fault_o <= cmd_ok & fault_r;
         wprot_o <= cmd_ok & wprot;
         servo_clk_o <= sclk;
         write_en_o <= wg_r;
         read_en_o <= rg_r;
         // write data taken on write clock
         if (edge_rise(wclk, s3_r[20])) begin
            wr_data_o <= wdat;
         end
      end
   end

   // wishbone slave, ack one cycle after strobe
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl_r <= `DDH_CTRL_RST;
         plug_r <= 5'h00;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            if (wb_we_i) begin
               if (wb_adr_i == `DDH_ADR_CTRL) begin
                  if (wb_sel_i[0]) begin
                     ctrl_r[7:0] <= wb_dat_i[7:0];
                  end
                  if (wb_sel_i[1]) begin
                     ctrl_r[15:8] <= wb_dat_i[15:8];
                  end
               end else if (wb_adr_i == `DDH_ADR_ADDR && wb_sel_i[0]) begin
                  plug_r <= wb_dat_i[4:0];
               end
               wb_dat_o <= 32'h00000000;
            end else if (wb_adr_i == `DDH_ADR_CTRL) begin
               wb_dat_o <= {16'h0000, ctrl_r};
            end else if (wb_adr_i == `DDH_ADR_STAT) begin
               wb_dat_o <= {21'h000000, am_found_o, pri_res_r, reserved_r, busy_o, wprot,
                  fault_r, seek_err_r, on_cyl, rg_r, wg_r, selected_r};
            end else if (wb_adr_i == `DDH_ADR_CYL) begin
               wb_dat_o <= {22'h000000, cyl_r};
            end else if (wb_adr_i == `DDH_ADR_HEAD) begin
               wb_dat_o <= {28'h0000000, head_r};
            end else if (wb_adr_i == `DDH_ADR_ADDR) begin
               wb_dat_o <= {27'h0000000, plug_r};
            end else begin
               wb_dat_o <= 32'h00000000;
            end
         end
      end
   end
endmodule // ddh_host_if
`default_nettype wire

// [core/ddh_defines.vh]
// constants for the drive-side host interface block
// assumes a 125 MHz clk_i (8 ns period)
`ifndef DDH_DEFINES_VH
`define DDH_DEFINES_VH
// wishbone register byte addresses
`define DDH_ADR_CTRL 8'h00
`define DDH_ADR_STAT 8'h04
`define DDH_ADR_CYL 8'h08
`define DDH_ADR_HEAD 8'h0C
`define DDH_ADR_ADDR 8'h10
// control register bit positions and reset value
`define DDH_CTRL_DUAL 0
`define DDH_CTRL_SWPROT 1
`define DDH_CTRL_SPEED 2
`define DDH_CTRL_ONCYL 3
`define DDH_CTRL_DCFLT 4
`define DDH_CTRL_FSKFLT 5
`define DDH_CTRL_WRFLT 6
`define DDH_CTRL_OUTFLD 7
`define DDH_CTRL_AMDET 8
`define DDH_CTRL_INDEX 9
`define DDH_CTRL_OTHPRI 10
`define DDH_CTRL_OTHHOLD 11
`define DDH_CTRL_CHEN 12
`define DDH_CTRL_RST 16'h0000
// timing: clock period, figures as printed, derived counts
`define DDH_CLK_NS 8
`define DDH_SEL_NS 600
`define DDH_SEL_CYC (`DDH_SEL_NS / `DDH_CLK_NS)
`define DDH_SEEK_MS 250
`define DDH_SEEK_CYC (`DDH_SEEK_MS * 1000000 / `DDH_CLK_NS)
`define DDH_OFS_US 2750
`define DDH_OFS_CYC (`DDH_OFS_US * 1000 / `DDH_CLK_NS)
// cylinder limit and default address
`define DDH_CYL_MAX 10'd822
`define DDH_ADDR_NOPLUG 4'h7
// tag 3 bus bit positions, and the bus bit for priority select
`define DDH_T3_WGATE 0
`define DDH_T3_RGATE 1
`define DDH_T3_OFSP 2
`define DDH_T3_OFSM 3
`define DDH_T3_FCLR 4
`define DDH_T3_AME 5
`define DDH_T3_RTZ 6
`define DDH_T3_REL 9
`define DDH_PRI_BIT 9
`endif

// [dv/ddh_host_if_sva.sv]
// port-level assertions for the drive-side host interface
// bound into ddh_host_if; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module ddh_host_if_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cable_sense_i,
   input wire logic unit_sel_tag_i,
   input wire logic unit_selected_o,
   input wire logic ready_o,
   input wire logic on_cyl_o,
   input wire logic seek_err_o,
   input wire logic fault_o,
   input wire logic wprot_o,
   input wire logic index_o,
   input wire logic write_en_o,
   input wire logic read_en_o,
   input wire logic read_sync_o,
   input wire logic rtz_o,
   input wire logic [1:0] offset_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_sel_cause;
      $rose(unit_selected_o) |-> $past(unit_sel_tag_i, 3) && $past(cable_sense_i, 3);
   endproperty
   a_sel_cause: assert property (p_sel_cause) else $error("select without tag");
   property p_cable_loss;
      $fell(cable_sense_i) |-> ##[1:6] !unit_selected_o;
   endproperty
   a_cable_loss: assert property (p_cable_loss) else $error("select kept");
   property p_ready;
      ready_o |-> on_cyl_o && !fault_o;
   endproperty
   a_ready: assert property (p_ready) else $error("ready while not usable");
   property p_unsel_quiet;
      !unit_selected_o [*2] |-> !ready_o && !on_cyl_o && !fault_o && !seek_err_o && !wprot_o;
   endproperty
   a_unsel_quiet: assert property (p_unsel_quiet) else $error("status while unselected");
   property p_wgate;
      $rose(write_en_o) |-> !$past(seek_err_o) && !$past(fault_o) && !$past(wprot_o);
   endproperty
   a_wgate: assert property (p_wgate) else $error("write gate accepted");
   property p_rsync;
      read_sync_o |-> ##[0:2] read_en_o;
   endproperty
   a_rsync: assert property (p_rsync) else $error("sync without read gate");
   property p_offset;
      $rose(|offset_o) |-> ##1 !on_cyl_o [*8];
   endproperty
   a_offset: assert property (p_offset) else $error("on cylinder during offset");
   property p_rtz;
      rtz_o |-> ##[0:3] !seek_err_o;
   endproperty
   a_rtz: assert property (p_rtz) else $error("seek error kept");
   property p_index;
      index_o |-> unit_selected_o ##1 !index_o;
   endproperty
   a_index: assert property (p_index) else $error("index pulse wrong");
endmodule // ddh_host_if_sva
bind ddh_host_if ddh_host_if_sva i_sva (
   .clk_i(clk_i), .rst_i(rst_i), .cable_sense_i(cable_sense_i),
   .unit_sel_tag_i(unit_sel_tag_i), .unit_selected_o(unit_selected_o),
   .ready_o(ready_o), .on_cyl_o(on_cyl_o), .seek_err_o(seek_err_o),
   .fault_o(fault_o), .wprot_o(wprot_o), .index_o(index_o),
   .write_en_o(write_en_o), .read_en_o(read_en_o), .read_sync_o(read_sync_o),
   .rtz_o(rtz_o), .offset_o(offset_o));
`default_nettype wire

// [dv/ddh_ctl_model.sv]
// controller model for the command and data cables
// tags, bus and sense driven from clk_i edges; servo clock free-running; bench calls its tasks
`timescale 1ns/10ps
`default_nettype none
module ddh_ctl_model (
   input wire logic clk_i,
   output logic [3:0] tags_o,
   output logic [3:0] usel_o,
   output logic [9:0] bus_o,
   output logic sense_o,
   output logic sclk_o,
   output logic wclk_o,
   output logic wdat_o
);
   logic wr_arm = 1'b0;
   initial begin
      tags_o = 4'h0;
      usel_o = 4'h0;
      bus_o = 10'h000;
      sense_o = 1'b1;
      wdat_o = 1'b0;
   end
   initial begin
      sclk_o = 1'b0;
      #13;
      forever #40 sclk_o = ~sclk_o;
   end
   assign wclk_o = wr_arm & sclk_o;
   always @(negedge sclk_o) wdat_o <= ~wdat_o;
   task automatic cmd(input logic [3:0] t, input logic [3:0] u, input logic [9:0] b);
      @(posedge clk_i);
      usel_o <= u;
      bus_o <= b;
      if (t[3])
         wr_arm <= b[0];
      repeat ((t[3] && b[0]) ? 32 : 3) @(posedge clk_i);
      tags_o <= t;
      repeat (8) @(posedge clk_i);
      tags_o <= 4'h0;
      repeat (3) @(posedge clk_i);
      usel_o <= ~u;
      bus_o <= ~b;
   endtask
   task automatic cable(input logic s);
      @(posedge clk_i);
      sense_o <= s;
      repeat (6) @(posedge clk_i);
   endtask
endmodule // ddh_ctl_model
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the drive-side host interface
// ddh_ctl_model plays the controller; registers over wishbone
`timescale 1ns/10ps
`default_nettype none
`include "ddh_defines.vh"
module tb_top;
   logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, rdat;
   logic [3:0] wb_sel_i;
   wire [3:0] tg, us;
   wire [9:0] bus;
   wire sense, sclk, wclk, wdat;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, sel, busy, rdy, idx, oncyl, serr, flt, wp, amf, wen, ren, sco, amw, wrd;
   wire [1:0] ofs;
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   ddh_host_if #(.SEEK_CYC(200), .OFS_CYC(50)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .unit_sel_tag_i(tg[0]),
      .unit_sel_i(us), .cable_sense_i(sense), .tag1_i(tg[1]), .tag2_i(tg[2]),
      .tag3_i(tg[3]), .bus_i(bus), .servo_clk_i(sclk), .write_clk_i(wclk),
      .write_data_i(wdat), .unit_selected_o(sel), .busy_o(busy), .ready_o(rdy),
      .index_o(idx), .on_cyl_o(oncyl), .seek_err_o(serr), .fault_o(flt), .wprot_o(wp),
      .am_found_o(amf), .servo_clk_o(sco), .write_en_o(wen), .read_en_o(ren),
      .am_write_o(amw), .read_sync_o(), .rtz_o(), .offset_o(ofs), .wr_data_o(wrd));
   ddh_ctl_model i_ctl (.clk_i(clk_i), .tags_o(tg), .usel_o(us), .bus_o(bus),
      .sense_o(sense), .sclk_o(sclk), .wclk_o(wclk), .wdat_o(wdat));
   task automatic stop_test();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_we_i <= we;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic gap();
      repeat (3) @(posedge clk_i);
   endtask
   task automatic t_regs();
      wb(1'b0, `DDH_ADR_CTRL, 32'h0);
      chk(rdat, {16'h0000, `DDH_CTRL_RST});
      wb(1'b1, 8'h20, 32'hFFFF);
      wb(1'b0, 8'h20, 32'h0);
      chk(rdat, 32'h0);
   endtask
   task automatic t_sel();
      i_ctl.cmd(4'h1, `DDH_ADDR_NOPLUG, 10'h000);
      chk(sel, 1'b1);
      wb(1'b1, `DDH_ADR_CTRL, 32'h100C);
      gap();
      chk(rdy, 1'b1);
      wb(1'b1, `DDH_ADR_ADDR, 32'h15);
      i_ctl.cmd(4'h1, 4'h7, 10'h000);
      chk({sel, rdy}, 2'b00);
      i_ctl.cmd(4'h1, 4'h5, 10'h000);
      chk(sel, 1'b1);
      i_ctl.cable(1'b0);
      i_ctl.cmd(4'h1, 4'h5, 10'h000);
      chk(sel, 1'b0);
      i_ctl.cable(1'b1);
      i_ctl.cmd(4'h1, 4'h5, 10'h000);
   endtask
   task automatic t_seek();
      logic [1:0] b;
      i_ctl.cmd(4'h2, 4'h5, 10'd822);
      wb(1'b0, `DDH_ADR_CYL, 32'h0);
      chk({rdat[9:0], serr}, {10'd822, 1'b0});
      i_ctl.cmd(4'h2, 4'h5, 10'd823);
      chk(serr, 1'b1);
      i_ctl.cmd(4'h8, 4'h5, 10'h001);
      chk(wen, 1'b0);
      i_ctl.cmd(4'h4, 4'h5, 10'h00A);
      wb(1'b0, `DDH_ADR_HEAD, 32'h0);
      chk(rdat, 32'hA);
      i_ctl.cmd(4'h8, 4'h5, 10'h040);
      wb(1'b0, `DDH_ADR_CYL, 32'h0);
      chk({rdat[30:0], serr}, 32'h0);
      wb(1'b0, `DDH_ADR_HEAD, 32'h0);
      chk(rdat, 32'h0);
      wb(1'b1, `DDH_ADR_CTRL, 32'h1004);
      i_ctl.cmd(4'h2, 4'h5, 10'h00A);
      chk(serr, 1'b0);
      repeat (200) @(posedge clk_i);
      chk(serr, 1'b1);
      i_ctl.cmd(4'h8, 4'h5, 10'h040);
      chk(serr, 1'b0);
      wb(1'b1, `DDH_ADR_CTRL, 32'h108C);
      gap();
      chk(serr, 1'b1);
      wb(1'b1, `DDH_ADR_CTRL, 32'h100C);
      i_ctl.cmd(4'h8, 4'h5, 10'h040);
      i_ctl.cmd(4'h8, 4'h5, 10'h021);
      chk({wen, amw}, 2'b11);
      @(negedge clk_i);
      b = {sco, wrd};
      repeat (5) @(negedge clk_i);
      chk(sco ^ b[1], 1'b1);
      repeat (5) @(negedge clk_i);
      chk(wrd ^ b[0], 1'b1);
      i_ctl.cmd(4'h8, 4'h5, 10'h022);
      chk({wen, ren, amw, flt}, 4'b0100);
      wb(1'b1, `DDH_ADR_CTRL, 32'h110C);
      gap();
      chk(amf, 1'b1);
      wb(1'b1, `DDH_ADR_CTRL, 32'h100C);
      i_ctl.cmd(4'h8, 4'h5, 10'h000);
   endtask
   task automatic t_fault();
      wb(1'b1, `DDH_ADR_CTRL, 32'h101C);
      gap();
      chk({flt, rdy}, 2'b10);
      i_ctl.cmd(4'h8, 4'h5, 10'h010);
      chk(flt, 1'b1);
      wb(1'b1, `DDH_ADR_CTRL, 32'h100E);
      i_ctl.cmd(4'h8, 4'h5, 10'h001);
      chk({wp, wen, flt}, 3'b101);
      wb(1'b1, `DDH_ADR_CTRL, 32'h100C);
      i_ctl.cmd(4'h8, 4'h5, 10'h010);
      chk({flt, rdy}, 2'b01);
      wb(1'b1, `DDH_ADR_CTRL, 32'h1004);
      i_ctl.cmd(4'h8, 4'h5, 10'h002);
      chk(flt, 1'b1);
      wb(1'b1, `DDH_ADR_CTRL, 32'h100C);
      i_ctl.cmd(4'h8, 4'h5, 10'h010);
   endtask
   task automatic t_offset();
      i_ctl.cmd(4'h8, 4'h5, 10'h004);
      chk({ofs, oncyl}, 3'b010);
      repeat (50) @(posedge clk_i);
      chk(oncyl, 1'b1);
      i_ctl.cmd(4'h8, 4'h5, 10'h008);
      chk({ofs, oncyl}, 3'b100);
      repeat (50) @(posedge clk_i);
      i_ctl.cmd(4'h8, 4'h5, 10'h000);
   endtask
   task automatic t_index();
      int n;
      n = 0;
      fork
         wb(1'b1, `DDH_ADR_CTRL, 32'h120C);
         repeat (10) begin
            @(negedge clk_i);
            if (idx === 1'b1)
               n++;
         end
      join
      @(posedge clk_i);
      chk(n, 1);
      wb(1'b1, `DDH_ADR_CTRL, 32'h100C);
   endtask
   task automatic t_dual();
      wb(1'b1, `DDH_ADR_CTRL, 32'h180D);
      i_ctl.cmd(4'h1, 4'h5, 10'h000);
      chk(busy, 1'b1);
      i_ctl.cmd(4'h1, 4'h5, 10'h200);
      wb(1'b0, `DDH_ADR_STAT, 32'h0);
      chk({sel, busy, rdat[9:8]}, 4'b1011);
      i_ctl.cmd(4'h8, 4'h5, 10'h200);
      wb(1'b0, `DDH_ADR_STAT, 32'h0);
      chk(rdat[9:8], 2'b00);
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      rst_i = 1'b1;
      wb_we_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'hF;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_sel();
      t_seek();
      t_fault();
      t_offset();
      t_index();
      t_dual();
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
